// ---- verilog/wdt_top.sv ----
// Watchdog timer unit: free-running divider, time-out flag, grace window,
// watchdog system reset and a Wishbone register file.
// Assumes the unlock strobe and power-fail pulse come from logic on sys_clk_in.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`default_nettype none

module wdt_top #(
  parameter int LOG2_INT0 = 17, // Interval for select 00
  parameter int LOG2_INT1 = 20, // Interval for select 01
  parameter int LOG2_INT2 = 23, // Interval for select 10
  parameter int LOG2_INT3 = 26, // Interval for select 11
  parameter int MACH_CLKS = wdt_pkg::WDT_MACH_CLKS_DEF // Clocks per machine cycle
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic pfail_rst_in,
  input wire logic ta_unlock_in,
  input wire wdt_pkg::wdt_wb_req_t wb_req_in,
  output var wdt_pkg::wdt_wb_rsp_t wb_rsp_out,
  output var logic wdog_irq_out,
  output var logic wdog_sys_rst_out
);
  import wdt_pkg::*;

  // ******************************
  // Helpers
  // ******************************

  // All-ones mask of the low bits that make up the selected interval
  function automatic logic [WDT_CNT_W-1:0] int_mask(input logic [1:0] sel);
    int n;
    case (sel)
      2'h0: n = LOG2_INT0;
      2'h1: n = LOG2_INT1;
      2'h2: n = LOG2_INT2;
      default: n = LOG2_INT3;
    endcase
    int_mask = WDT_CNT_W'((64'h1 << n) - 64'h1);
  endfunction

  localparam int HOLD_CLKS = WDT_HOLD_MACH * MACH_CLKS; // Reset length in clocks
  localparam logic [7:0] HOLD_LAST = 8'(HOLD_CLKS - 1);
  localparam logic [9:0] GRACE_LAST = WDT_GRACE_CLKS - 10'h1;

  // ******************************
  // State declarations
  // ******************************
  logic ack; // Bus answer strobe
  logic [31:0] rdat; // Bus read data
  logic next_ack;
  logic [31:0] next_rdat;

  logic rst_en; // wdog_reset_enable
  logic to_flag; // wdog_timeout_flag
  logic cause; // wdog_reset_cause_flag
  logic restart; // wdog_restart, visible for one cycle
  logic [1:0] sel; // interval_sel_hi/lo
  logic xie; // extended_int_enable
  logic gie; // global_int_enable
  logic ta_armed; // One protected write allowed
  logic irq; // Interrupt request
  logic next_rst_en;
  logic next_to_flag;
  logic next_cause;
  logic next_restart;
  logic [1:0] next_sel;
  logic next_xie;
  logic next_gie;
  logic next_ta_armed;
  logic next_irq;

  wdt_state_t state; // Run, grace or reset hold
  wdt_state_t next_state;
  logic [WDT_CNT_W-1:0] cnt; // Main divider
  logic [WDT_CNT_W-1:0] next_cnt;
  logic [9:0] grace; // Clocks since time-out
  logic [9:0] next_grace;
  logic [7:0] hold; // Clocks of reset so far
  logic [7:0] next_hold;
  logic sys_rst; // Watchdog system reset
  logic next_sys_rst;

  // Decoded bus and timer events
  logic wr_commit; // Write takes effect at the ack edge
  logic wr_watchdog_control_status;
  logic wr_clock_control;
  logic wr_inten;
  logic prot_ok; // Protected bits may change
  logic timeout; // Selected interval elapses this cycle
  logic fire; // Grace expired with reset armed
  logic [7:0] watchdog_control_status_rd;

  // ******************************
  // Bus decode
  // ******************************

  // Write and decode terms; a write needs byte lane 0
  always_comb
  begin
    wr_commit = ack && wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && wb_req_in.sel[0];
    wr_watchdog_control_status = wr_commit && (wb_req_in.adr == WDT_OFF_WATCHDOG_CONTROL_STATUS);
    wr_clock_control = wr_commit && (wb_req_in.adr == WDT_OFF_CLOCK_CONTROL);
    wr_inten = wr_commit && (wb_req_in.adr == WDT_OFF_INTEN);
    prot_ok = wr_watchdog_control_status && ta_armed;
    watchdog_control_status_rd = 8'h00;
    watchdog_control_status_rd[WDT_B_RESTART] = restart;
    watchdog_control_status_rd[WDT_B_RST_EN] = rst_en;
    watchdog_control_status_rd[WDT_B_CAUSE] = cause;
    watchdog_control_status_rd[WDT_B_TOFLAG] = to_flag;
  end

  // Answer one cycle after the request, drop it the cycle after
  always_comb
  begin
    next_ack = wb_req_in.cyc && wb_req_in.stb && !ack;
    next_rdat = 32'h0000_0000;
    if (next_ack)
    begin
      case (wb_req_in.adr)
        WDT_OFF_WATCHDOG_CONTROL_STATUS: next_rdat = {24'h00_0000, watchdog_control_status_rd};
        WDT_OFF_CLOCK_CONTROL: next_rdat = {24'h00_0000, sel, 6'h00};
        WDT_OFF_INTEN: next_rdat = {24'h00_0000, gie, 2'h0, xie, 4'h0};
        default: next_rdat = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Bus answer registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack <= 1'b0;
      rdat <= 32'h0000_0000;
    end
    else
    begin
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // ******************************
  // Control and status bits
  // ******************************

  // Next values of software-visible bits
  always_comb
  begin
    next_rst_en = rst_en;
    next_to_flag = to_flag;
    next_cause = cause;
    next_restart = 1'b0;
    next_sel = sel;
    next_xie = xie;
    next_gie = gie;
    next_ta_armed = ta_armed;
    // Unlock arms and wins over a write in the same cycle; any other write to the protected register uses it up
    if (ta_unlock_in)
      next_ta_armed = 1'b1;
    else if (wr_watchdog_control_status)
      next_ta_armed = 1'b0;
    if (prot_ok)
    begin
      next_rst_en = wb_req_in.dat[WDT_B_RST_EN];
      next_restart = wb_req_in.dat[WDT_B_RESTART];
      if (!wb_req_in.dat[WDT_B_TOFLAG])
        next_to_flag = 1'b0;
    end
    // Cause flag is not protected; software can only clear it
    if (wr_watchdog_control_status && !wb_req_in.dat[WDT_B_CAUSE])
      next_cause = 1'b0;
    if (wr_clock_control)
      next_sel = {wb_req_in.dat[WDT_B_SEL_HI], wb_req_in.dat[WDT_B_SEL_LO]};
    if (wr_inten)
    begin
      next_xie = wb_req_in.dat[WDT_B_XIE];
      next_gie = wb_req_in.dat[WDT_B_GIE];
    end
    // Hardware set wins over a clear in the same cycle
    if (timeout)
      next_to_flag = 1'b1;
    if (fire)
    begin
      next_cause = 1'b1;
      next_to_flag = 1'b0;
      next_sel = WDT_SEL_RST;
      next_restart = 1'b0;
      next_ta_armed = 1'b0;
      // Enable stays set across its own reset
      next_rst_en = 1'b1;
    end
    // Power-fail returns the control bits to their power-on values
    if (pfail_rst_in)
    begin
      next_rst_en = 1'b0;
      next_to_flag = 1'b0;
      next_cause = 1'b0;
      next_restart = 1'b0;
      next_sel = WDT_SEL_RST;
      next_xie = 1'b0;
      next_gie = 1'b0;
      next_ta_armed = 1'b0;
    end
    next_irq = next_to_flag && next_xie && next_gie;
  end

  // Control registers; power-on reset disables the watchdog
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_en <= 1'b0;
      to_flag <= 1'b0;
      cause <= 1'b0;
      restart <= 1'b0;
      sel <= WDT_SEL_RST;
      xie <= 1'b0;
      gie <= 1'b0;
      ta_armed <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      rst_en <= next_rst_en;
      to_flag <= next_to_flag;
      cause <= next_cause;
      restart <= next_restart;
      sel <= next_sel;
      xie <= next_xie;
      gie <= next_gie;
      ta_armed <= next_ta_armed;
      irq <= next_irq;
    end
  end

  // ******************************
  // Divider, grace window, reset
  // ******************************

  // Time-out when the low bits of the divider are all ones
  always_comb
  begin
    timeout = (state != WDT_HOLD) && ((cnt & int_mask(sel)) == int_mask(sel));
    // Reset only when still armed at the end of the grace window
    fire = (state == WDT_GRACE) && (grace == GRACE_LAST) && rst_en && !restart;
  end

  // Next values of the timer
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + WDT_CNT_W'(1);
    next_grace = grace;
    next_hold = hold;
    next_sys_rst = 1'b0;
    case (state)
      WDT_RUN:
      begin
        // Grace window opens at every time-out
        if (timeout)
        begin
          next_state = WDT_GRACE;
          next_grace = 10'h000;
        end
      end
      WDT_GRACE:
      begin
        next_grace = grace + 10'h001;
        if (fire)
        begin
          next_state = WDT_HOLD;
          next_hold = 8'h00;
          next_sys_rst = 1'b1;
        end
        else if (grace == GRACE_LAST)
          next_state = WDT_RUN; // Unarmed: plain interval timer
      end
      WDT_HOLD:
      begin
        // Count held at start while the system is in reset
        next_cnt = '0;
        next_hold = hold + 8'h01;
        if (hold == HOLD_LAST)
          next_state = WDT_RUN;
        else
          next_sys_rst = 1'b1;
      end
      default: next_state = WDT_RUN;
    endcase
    // Restart clears the count and cancels a pending reset
    if (restart && (state != WDT_HOLD))
    begin
      next_cnt = '0;
      next_state = WDT_RUN;
    end
    if (pfail_rst_in)
    begin
      next_state = WDT_RUN;
      next_cnt = '0;
      next_sys_rst = 1'b0;
    end
  end

  // Timer registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state <= WDT_RUN;
      cnt <= '0;
      grace <= 10'h000;
      hold <= 8'h00;
      sys_rst <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      grace <= next_grace;
      hold <= next_hold;
      sys_rst <= next_sys_rst;
    end
  end

  // ******************************
  // Outputs, all from flip-flops
  // ******************************
  assign wb_rsp_out.ack = ack;
  assign wb_rsp_out.dat = rdat;
  assign wdog_irq_out = irq;
  assign wdog_sys_rst_out = sys_rst;

endmodule

`default_nettype wire

// ---- verilog/wdt_pkg.sv ----
// Constants, register map and carrier types of the watchdog timer unit.
// Assumes a classic Wishbone master on the same clock as the block.
`default_nettype none

package wdt_pkg;

  // ******************************
  // Register map (byte addresses)
  // ******************************
  localparam logic [7:0] WDT_OFF_WATCHDOG_CONTROL_STATUS = 8'h00; // watchdog_control_status
  localparam logic [7:0] WDT_OFF_CLOCK_CONTROL = 8'h04; // clock_control
  localparam logic [7:0] WDT_OFF_INTEN = 8'h08; // interrupt enables

  // ******************************
  // Field positions
  // ******************************
  localparam int WDT_B_RESTART = 0; // wdog_restart
  localparam int WDT_B_RST_EN = 1; // wdog_reset_enable
  localparam int WDT_B_CAUSE = 2; // wdog_reset_cause_flag
  localparam int WDT_B_TOFLAG = 3; // wdog_timeout_flag
  localparam int WDT_B_SEL_LO = 6; // interval_sel_lo
  localparam int WDT_B_SEL_HI = 7; // interval_sel_hi
  localparam int WDT_B_XIE = 4; // extended_int_enable
  localparam int WDT_B_GIE = 7; // global_int_enable

  // ******************************
  // Reset values and counts
  // ******************************
  localparam logic [1:0] WDT_SEL_RST = 2'h0; // Shortest interval
  localparam logic [9:0] WDT_GRACE_CLKS = 10'h200; // 512 clocks after time-out
  localparam int WDT_MACH_CLKS_DEF = 4; // Clocks per machine cycle
  localparam int WDT_HOLD_MACH = 2; // Reset length in machine cycles
  localparam int WDT_CNT_W = 26; // Enough for the longest interval

  // ******************************
  // States, Gray along run-grace-hold
  // ******************************
  typedef enum logic [1:0] {
    WDT_RUN = 2'b00,
    WDT_GRACE = 2'b01,
    WDT_HOLD = 2'b11
  } wdt_state_t;

  // ******************************
  // Wishbone carriers
  // ******************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wdt_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wdt_wb_rsp_t;

endpackage

`default_nettype wire

// ---- tb/wdt_top_properties.sv ----
// Port checker for the watchdog timer unit.
// Assumes it is bound into wdt_top and sees one clock domain.
`default_nettype none

module wdt_top_properties #(
  parameter int LOG2_INT0 = 17 // Shortest interval, as in the design
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic pfail_rst_in,
  input wire logic ta_unlock_in,
  input wire wdt_pkg::wdt_wb_req_t wb_req_in,
  input wire wdt_pkg::wdt_wb_rsp_t wb_rsp_out,
  input wire logic wdog_irq_out,
  input wire logic wdog_sys_rst_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import wdt_pkg::*;
  // ****************
  // Clocks since power event or bite
  // ****************
  logic [31:0] age; // No bite can come sooner than one interval plus grace
  logic [31:0] next_age;
  // Restart the age on power-fail and while a bite is held
  always_comb
  begin
    next_age = (pfail_rst_in || wdog_sys_rst_out) ? 32'h0 : age + 32'h1;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      age <= 32'h0;
    else
      age <= next_age;
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence taken_s;
    wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  endsequence
  sequence hold_s;
    wdog_sys_rst_out [*8] ##1 !wdog_sys_rst_out;
  endsequence
  ack_answer_a: assert property (taken_s |=> wb_rsp_out.ack)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack held longer than one cycle");
  idle_dat_a: assert property (!wb_rsp_out.ack |-> wb_rsp_out.dat == 32'h0)
    else $error("read data not zero outside ack");
  upper_zero_a: assert property (wb_rsp_out.dat[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  unmapped_zero_a: assert property (taken_s ##0 (wb_req_in.adr != WDT_OFF_WATCHDOG_CONTROL_STATUS
    && wb_req_in.adr != WDT_OFF_CLOCK_CONTROL && wb_req_in.adr != WDT_OFF_INTEN)
    |=> wb_rsp_out.dat == 32'h0) else $error("unmapped read not zero");
  bite_hold_a: assert property ($rose(wdog_sys_rst_out) |-> hold_s)
    else $error("system reset length wrong");
  bite_late_a: assert property ($rose(wdog_sys_rst_out) |->
    age >= 32'((1 << LOG2_INT0) + 500)) else $error("system reset too early");
  pfail_quiet_a: assert property (pfail_rst_in |-> ##2 !wdog_sys_rst_out [*8])
    else $error("system reset after power-fail");
  bite_irq_a: assert property ($rose(wdog_sys_rst_out) |-> ##2 !wdog_irq_out)
    else $error("interrupt kept through watchdog reset");
endmodule

bind wdt_top wdt_top_properties #(.LOG2_INT0(LOG2_INT0)) u_wdt_top_properties (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .pfail_rst_in(pfail_rst_in),
  .ta_unlock_in(ta_unlock_in),
  .wb_req_in(wb_req_in),
  .wb_rsp_out(wb_rsp_out),
  .wdog_irq_out(wdog_irq_out),
  .wdog_sys_rst_out(wdog_sys_rst_out)
);

`default_nettype wire

// ---- tb/wdt_top_tb_top.sv ----
// Self-checking bench for the watchdog timer unit.
// Assumes shortened intervals of 2^10..2^13 clocks and four clocks a machine cycle.
`default_nettype none

module wdt_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import wdt_pkg::*;
  typedef struct packed {logic we; logic [7:0] adr; logic [7:0] wd; logic [7:0] ex;} wdt_row_t;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic pfail_rst_in = 1'b0;
  logic ta_unlock_in = 1'b0;
  wdt_wb_req_t wb_req_in = '0;
  wdt_wb_rsp_t wb_rsp_out;
  logic wdog_irq_out;
  logic wdog_sys_rst_out;
  logic prev_rst = 1'b0; // Edge finder for bite counting
  int num_errors = 0;
  int comparisons = 0;
  int bites = 0;
  int n;
  int b0;
  logic [7:0] rd;
  // Register cases: reads carry their expected value
  wdt_row_t rows [10] = '{'{0, 8'h04, 8'h00, 8'h00}, '{0, 8'h00, 8'h00, 8'h00},
    '{1, 8'h08, 8'h90, 8'h00}, '{0, 8'h08, 8'h00, 8'h90}, '{1, 8'h04, 8'hc0, 8'h00},
    '{0, 8'h04, 8'h00, 8'hc0}, '{1, 8'h00, 8'h02, 8'h00}, '{0, 8'h00, 8'h00, 8'h00},
    '{1, 8'h0c, 8'hff, 8'h00}, '{0, 8'h0c, 8'h00, 8'h00}};

  wdt_top #(.LOG2_INT0(10), .LOG2_INT1(11), .LOG2_INT2(12), .LOG2_INT3(13)) u_wdt_top (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .pfail_rst_in(pfail_rst_in),
    .ta_unlock_in(ta_unlock_in),
    .wb_req_in(wb_req_in),
    .wb_rsp_out(wb_rsp_out),
    .wdog_irq_out(wdog_irq_out),
    .wdog_sys_rst_out(wdog_sys_rst_out)
  );

  always #12.5 sys_clk_in = ~sys_clk_in;
  // Count rising edges of the system reset
  always @(posedge sys_clk_in)
  begin
    if (wdog_sys_rst_out === 1'b1 && prev_rst !== 1'b1)
      bites++;
    prev_rst = wdog_sys_rst_out;
  end

  task end_of_test;
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int k;
    k = 0;
    wb_req_in <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'h1, dat:{24'h0, wd}};
    do
    begin
      @(posedge sys_clk_in);
      k++;
    end
    while (wb_rsp_out.ack !== 1'b1 && k < 20);
    rd = wb_rsp_out.dat[7:0];
    wb_req_in <= '0;
    @(posedge sys_clk_in);
    if (k >= 20)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_of_test();
    end
  endtask

  // Unlock pulse, then the protected control write
  task prot(input logic [7:0] wd);
    ta_unlock_in <= 1'b1;
    @(posedge sys_clk_in);
    ta_unlock_in <= 1'b0;
    wb(1'b1, WDT_OFF_WATCHDOG_CONTROL_STATUS, wd);
  endtask

  // Bounded wait: which 0 is the interrupt, 1 the system reset
  task wait_hi(input int which, input int lim);
    n = 0;
    while (((which == 0) ? wdog_irq_out : wdog_sys_rst_out) !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= lim)
    begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_of_test();
    end
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].adr, rows[i].wd);
      if (!rows[i].we)
        chk(rd, rows[i].ex);
    end
    // Each select: restart, time the flag, then time the repeat
    for (int s = 0; s < 4; s++)
    begin
      wb(1'b1, WDT_OFF_CLOCK_CONTROL, 8'(s << 6));
      prot(8'h01);
      wb(1'b0, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
      chk(rd & 8'h07, 8'h00);
      wait_hi(0, 10000);
      chk(n > (1 << (10 + s)) - 8 && n < (1 << (10 + s)) + 4, 1);
      prot(8'h00);
      wait_hi(0, 10000);
      chk(n > (1 << (10 + s)) - 10 && n <= (1 << (10 + s)), 1);
    end
    chk(bites, 0);
    // Armed watchdog left alone bites after interval plus grace
    wb(1'b1, WDT_OFF_CLOCK_CONTROL, 8'h40);
    prot(8'h03);
    wait_hi(1, 4000);
    chk(n > 2550 && n < 2570, 1);
    repeat (20) @(posedge sys_clk_in);
    wb(1'b0, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
    chk(rd & 8'h0f, 8'h06);
    wb(1'b0, WDT_OFF_CLOCK_CONTROL, 8'h00);
    chk(rd, 8'h00);
    wb(1'b1, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h02);
    wb(1'b0, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
    chk(rd & 8'h07, 8'h02);
    // Restart inside the grace window cancels the bite
    wait_hi(0, 3000);
    prot(8'h03);
    b0 = bites;
    repeat (700) @(posedge sys_clk_in);
    chk(bites - b0, 0);
    // A second write after one unlock leaves the protected bits alone
    wb(1'b1, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
    wb(1'b0, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
    chk(rd & 8'h07, 8'h02);
    // Let it bite again so the cause flag stands for the checks below
    wait_hi(1, 2000);
    repeat (20) @(posedge sys_clk_in);
    // Software disarm: no bite, counter still runs, cause untouched
    prot(8'h04);
    b0 = bites;
    repeat (1700) @(posedge sys_clk_in);
    chk(bites - b0, 0);
    wb(1'b0, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
    chk(rd & 8'h0f, 8'h0c);
    // Power-fail disarms and clears the control bits
    pfail_rst_in <= 1'b1;
    @(posedge sys_clk_in);
    pfail_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    wb(1'b0, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
    chk(rd, 8'h00);
    // Global enable alone must not raise the interrupt
    wb(1'b1, WDT_OFF_INTEN, 8'h80);
    b0 = bites;
    repeat (1700) @(posedge sys_clk_in);
    chk(bites - b0, 0);
    chk(wdog_irq_out, 1'b0);
    wb(1'b0, WDT_OFF_WATCHDOG_CONTROL_STATUS, 8'h00);
    chk(rd & 8'h0f, 8'h08);
    end_of_test();
  end
endmodule

`default_nettype wire
